/* dv/pmx_pin_model.sv */
// Purpose: Board side of one port's pins
// Assumes: Board drives only pins the device has released
// Notes:   An undriven pin without pull-up toggles so no stale level is read
`timescale 1ns/10ps
`default_nettype none
module pmx_pin_model #(
    parameter int W = 8
) (
    input  wire logic [0:0]   clock,
    input  wire logic [W-1:0] drv_out,
    input  wire logic [W-1:0] drv_oe,
    input  wire logic [W-1:0] pull_en,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output var  logic [W-1:0] pin
);
    logic [W-1:0] float_q = '0;
    always_ff @(posedge clock) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (drv_oe[i]) pin[i] = drv_out[i];
            else if (ext_en[i]) pin[i] = ext_val[i];
            else if (pull_en[i]) pin[i] = 1'b1;
            else pin[i] = float_q[i];
        end
    end
endmodule : pmx_pin_model
`default_nettype wire

/* dv/pmx_port_mux_bench.sv */
// Purpose: Self-checking bench for the port and pin-mux block
// Assumes: Zero-wait AHB-Lite slave, pins resolved by a board model
// Notes:   Fixed waits follow the write-to-pin and pin-to-peripheral latencies
`timescale 1ns/10ps
`default_nettype none
`include "pmx_consts.svh"
module pmx_port_mux_bench
    import pmx_pkg::*;
();
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b1;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0, hreadyout, hresp;
    logic [7:0] p8_in, p8_out, p8_oe, p8_pu, ext_en8 = '0, ext8 = '0, analog = '0;
    logic [6:0] p9_in, p9_out, p9_oe, ext_en9 = '0, ext9 = '0;
    pmx_periph_out_s periph_out = '0;
    pmx_periph_in_s periph_in;
    int num_errors = 0, n_checks = 0;
    always #4 clock = ~clock;
    pmx_port_mux dut_u (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .port_eight_in(p8_in), .port_eight_out(p8_out), .port_eight_oe(p8_oe),
        .port_eight_pullup(p8_pu), .port_nine_in(p9_in), .port_nine_out(p9_out), .port_nine_oe(p9_oe),
        .analog_port_in(analog), .periph_out, .periph_in);
    pmx_pin_model #(.W(8)) pins8_u (.clock, .drv_out(p8_out), .drv_oe(p8_oe), .pull_en(p8_pu), .ext_en(ext_en8),
        .ext_val(ext8), .pin(p8_in));
    pmx_pin_model #(.W(7)) pins9_u (.clock, .drv_out(p9_out), .drv_oe(p9_oe), .pull_en(7'h00), .ext_en(ext_en9),
        .ext_val(ext9), .pin(p9_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        htrans <= `PMX_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        q = hrdata;
    endtask : xfer
    task automatic t_reset;
        logic [7:0] zr [5] = '{`PMX_IDX_P8_FUNC, `PMX_IDX_P8_DIR, `PMX_IDX_P9_DIR, `PMX_IDX_P9_FUNC, 8'h10};
        chk(p8_oe, 8'h00);
        chk(p8_pu, 8'hff);
        chk(p9_oe, 7'h00);
        repeat (4) @(posedge clock);
        xfer(1'b0, `PMX_IDX_P8_DATA, 32'h0);
        chk(q, 32'hff);
        foreach (zr[i]) begin
            xfer(1'b0, zr[i], 32'h0);
            chk(q, 32'h0);
        end
    endtask : t_reset
    task automatic t_gpio;
        ext_en8 <= 8'hf0;
        ext8 <= 8'h60;
        xfer(1'b1, `PMX_IDX_P8_DIR, 32'h0f);
        xfer(1'b1, `PMX_IDX_P8_DATA, 32'ha5);
        repeat (5) @(posedge clock);
        chk(p8_oe, 8'h0f);
        chk(p8_out & 8'h0f, 8'h05);
        chk(p8_pu, 8'ha0);
        xfer(1'b0, `PMX_IDX_P8_DATA, 32'h0);
        chk(q, 32'h65);
        ext_en8 <= 8'h00;
    endtask : t_gpio
    task automatic t_odrain;
        xfer(1'b1, `PMX_IDX_P8_ODE, 32'h3);
        xfer(1'b1, `PMX_IDX_P8_DATA, 32'h08);
        xfer(1'b1, `PMX_IDX_P8_DIR, 32'h09);
        repeat (2) @(posedge clock);
        chk(p8_oe & 8'h09, 8'h01);
        chk(p8_out & 8'h01, 8'h00);
        xfer(1'b1, `PMX_IDX_P8_DIR, 32'h0);
        repeat (2) @(posedge clock);
        chk(p8_pu & 8'h09, 8'h00);
        xfer(1'b1, `PMX_IDX_P8_ODE, 32'h0);
        repeat (2) @(posedge clock);
        chk(p8_pu & 8'h09, 8'h08);
    endtask : t_odrain
    task automatic t_alt;
        xfer(1'b1, `PMX_IDX_P8_DATA, 32'hff);
        xfer(1'b1, `PMX_IDX_P8_DIR, 32'hff);
        xfer(1'b1, `PMX_IDX_P8_FUNC, 32'h49);
        periph_out <= 10'h100;
        repeat (2) @(posedge clock);
        chk(p8_out, 8'hbe);
        periph_out <= 10'h208;
        repeat (2) @(posedge clock);
        chk(p8_out, 8'hf7);
        xfer(1'b1, `PMX_IDX_P8_FUNC, 32'h24);
        periph_out <= 10'h050;
        repeat (2) @(posedge clock);
        chk(p8_out, 8'hdb);
        periph_out <= 10'h0a0;
        repeat (2) @(posedge clock);
        chk(p8_oe, 8'hdb);
        xfer(1'b1, `PMX_IDX_P8_FUNC, 32'h0);
        xfer(1'b1, `PMX_IDX_P8_DIR, 32'h0);
    endtask : t_alt
    task automatic t_inputs;
        ext_en8 <= 8'hff;
        ext_en9 <= 7'h7f;
        ext8 <= 8'h92;
        ext9 <= 7'h31;
        analog <= 8'hf7;
        repeat (5) @(posedge clock);
        chk(periph_in, 16'hc376);
        ext8 <= 8'h6d;
        ext9 <= 7'h4e;
        analog <= 8'h08;
        repeat (5) @(posedge clock);
        chk(periph_in, 16'h3c89);
        xfer(1'b1, `PMX_IDX_PA_DATA, 32'hff);
        xfer(1'b0, `PMX_IDX_PA_DATA, 32'h0);
        chk(q, 32'h08);
        // Board stops driving port nine; irq and count inputs are left for software to mask
        ext_en9 <= 7'h00;
    endtask : t_inputs
    task automatic t_nine;
        periph_out <= 10'h005;
        xfer(1'b1, `PMX_IDX_P9_FUNC, 32'h4c);
        repeat (2) @(posedge clock);
        chk(p9_oe & 7'h4c, 7'h4c);
        chk(p9_out & 7'h4c, 7'h44);
        xfer(1'b1, `PMX_IDX_P9_FUNC, 32'h0);
        xfer(1'b1, `PMX_IDX_P9_DIR, 32'h7f);
        xfer(1'b1, `PMX_IDX_P9_DATA, 32'h2a);
        repeat (4) @(posedge clock);
        chk(p9_oe, 7'h7f);
        chk(p9_out, 7'h2a);
        xfer(1'b0, `PMX_IDX_P9_DATA, 32'h0);
        chk(q, 32'h2a);
    endtask : t_nine
    task automatic give_verdict;
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_gpio();
        t_odrain();
        t_alt();
        t_inputs();
        t_nine();
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge clock);
        num_errors++;
        give_verdict();
    end
endmodule : pmx_port_mux_bench
`default_nettype wire

/* dv/pmx_port_mux_properties.sv */
// Purpose: Concurrent checks on the port and pin-mux block ports
// Assumes: Zero-wait slave, three-cycle pin-to-peripheral path
// Notes:   Pin checks wait until the synchronisers have filled
`timescale 1ns/10ps
`default_nettype none
`include "pmx_consts.svh"
module pmx_port_mux_props
    import pmx_pkg::*;
(
    input wire logic [0:0] clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:0] port_eight_oe,
    input wire logic [7:0] port_eight_pullup,
    input wire logic [6:0] port_nine_in,
    input wire logic [6:0] port_nine_oe,
    input wire logic [7:0] analog_port_in,
    input wire pmx_periph_in_s periph_in
);
    logic rd_ap;
    logic [2:0] up_q;
    logic [2:0] up_d;
    assign rd_ap = hsel && hready && htrans[1] && !hwrite;
    assign up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
    // Synchronisers still show reset values just after release
    always_ff @(posedge clock or posedge rst) begin
        if (rst) up_q <= 3'h0;
        else up_q <= up_d;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    idle_zero_a: assert property (!$past(rd_ap) |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    dir_hidden_a: assert property (rd_ap && haddr[9:2] == `PMX_IDX_P8_DIR |=> hrdata == 32'h0)
        else $error("direction register readable");
    analog_read_a: assert property (rd_ap && haddr[9:2] == `PMX_IDX_PA_DATA && up_q == 3'h7
        |=> hrdata == {24'h0, $past(analog_port_in, 3)}) else $error("analog port read wrong");
    pull_drive_a: assert property ((port_eight_oe & port_eight_pullup) == 8'h00)
        else $error("pull-up on while driving");
    reset_state_a: assert property ($fell(rst) |-> port_eight_oe == 8'h00
        && port_nine_oe == 7'h00 && port_eight_pullup == 8'hff) else $error("wrong state after reset");
    irq_count_a: assert property (up_q == 3'h7 |->
        periph_in.ext_irq_five == $past(port_nine_in[0], 3)
        && periph_in.timer9_count_in_b == $past(port_nine_in[5], 3)) else $error("pin not seen by irq or count");
    trigger_a: assert property (up_q == 3'h7 |->
        periph_in.conversion_trigger_n == $past(analog_port_in[3], 3)) else $error("trigger not from pin");
    cts_clock_a: assert property (up_q == 3'h7 |->
        periph_in.serial0_clear_to_send_n == periph_in.serial0_clock) else $error("clear-to-send not clock pin");
    cover property (rd_ap && haddr[9:2] == `PMX_IDX_PA_DATA);
    cover property (hsel && htrans[1] && hwrite && haddr[9:2] == `PMX_IDX_P8_DIR);
    cover property (port_nine_oe != 7'h00);
endmodule : pmx_port_mux_props
bind pmx_port_mux pmx_port_mux_props u_props (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .port_eight_oe, .port_eight_pullup, .port_nine_in, .port_nine_oe, .analog_port_in,
    .periph_in);
`default_nettype wire

/* hdl/pmx_consts.svh */
// Purpose: Offsets, reset values and field positions of the port and pin-mux block
// Assumes: AHB-Lite byte addresses, one register per aligned word
// Notes:   Printed offsets are not all multiples of four, so they are indices
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

`define PMX_IDX_P8_DATA   8'h18
`define PMX_IDX_P8_DIR    8'h1a
`define PMX_IDX_PA_DATA   8'h1e
`define PMX_IDX_P8_FUNC   8'h19
`define PMX_IDX_P9_DATA   8'h1c
`define PMX_IDX_P9_DIR    8'h1d
`define PMX_IDX_P9_FUNC   8'h1f
`define PMX_IDX_P8_ODE    8'h1b

`define PMX_P8_LATCH_RST  8'hff
`define PMX_P8_ZERO       8'h00
`define PMX_P9_ZERO       7'h00
`define PMX_ODE_ZERO      2'h0
`define PMX_WORD_ZERO     32'h0000_0000

`define PMX_HTRANS_NONSEQ 2'h2
`define PMX_HTRANS_SEQ    2'h3
`define PMX_ADDR_LSB      2
`define PMX_ADDR_MSB      9

`define PMX_PIN_TX0       0
`define PMX_PIN_RX0       1
`define PMX_PIN_SCK0      2
`define PMX_PIN_TX1       3
`define PMX_PIN_RX1       4
`define PMX_PIN_SCK1      5
`define PMX_PIN_CANTX     6
`define PMX_PIN_CANRX     7
`define PMX_P9_TO8        2
`define PMX_P9_TO9        3
`define PMX_P9_TOAB       6
`define PMX_PA_TRIG       3

`endif

/* hdl/pmx_pin_sync.sv */
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Single clock, asynchronous active-high reset
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module pmx_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } pmx_sync_s;

    pmx_sync_s state_q;
    pmx_sync_s state_d;

    always_comb begin
        state_d.meta = async_in;
        state_d.sync = state_q.meta;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.sync;
endmodule : pmx_pin_sync
`default_nettype wire

/* hdl/pmx_pkg.sv */
// Purpose: Types shared by the port and pin-mux block
// Assumes: Constants live in pmx_consts.svh
// Notes:   Peripheral-side signals grouped as packed structs
package pmx_pkg;

    typedef struct packed {
        logic       serial0_transmit;
        logic       serial1_transmit;
        logic       serial0_clock_out;
        logic       serial0_clock_oe;
        logic       serial1_clock_out;
        logic       serial1_clock_oe;
        logic       can_transmit;
        logic       timer8_out_a;
        logic       timer8_out_b;
        logic       timer9_out;
    } pmx_periph_out_s;

    typedef struct packed {
        logic       serial0_receive;
        logic       serial1_receive;
        logic       serial0_clock;
        logic       serial1_clock;
        logic       serial0_clear_to_send_n;
        logic       serial1_clear_to_send_n;
        logic       can_receive;
        logic       timer8_count_in_a;
        logic       timer8_count_in_b;
        logic       timer9_count_in_a;
        logic       timer9_count_in_b;
        logic       ext_irq_five;
        logic       ext_irq_six;
        logic       ext_irq_seven;
        logic       ext_irq_eight;
        logic       conversion_trigger_n;
    } pmx_periph_in_s;

    typedef struct packed {
        logic [7:0] port_eight_data;
        logic [7:0] port_eight_direction;
        logic [7:0] port_eight_function;
        logic [1:0] port_eight_open_drain;
        logic [6:0] port_nine_data;
        logic [6:0] port_nine_direction;
        logic [6:0] port_nine_function;
    } pmx_regs_s;

    typedef struct packed {
        logic       pend;
        logic       write;
        logic [7:0] index;
    } pmx_bus_s;

endpackage : pmx_pkg

/* hdl/pmx_port_mux.sv */
// Purpose: Ports eight, nine and the analog input port with pin-function multiplexing
// Assumes: AHB-Lite slave, single word transfers, pins synchronous to clock
// Notes:   Zero-wait-state slave; all outputs except the tied-off hreadyout and hresp come from flip-flops
//
// Summary of operation
// - Eight-pin port, per-pin direction
// - Reset: latch ones, direction/function zero
// - Direction plus function select alternate use
// - Pins 0,3 open drain, pull-up off
// - Pins 0,3 carry serial transmit outputs
// - Pins 1,4 carry serial receive inputs
// - Pins 2,5 serial clock and clear-to-send
// - Pin 6 CAN transmit, pin 7 receive
// - Input pin: data bit switches pull-up
// - Eight-pin direction register is write-only
// - Seven-pin port, per-pin direction
// - Reset clears seven-pin latch, direction, function
// - Timer output only when function bit set
// - Pins 0,1,4,5 feed counters and irqs
// - Irq inputs always sample pins
// - Counter inputs always connected to pins
// - Pins 2,3,6 carry timer outputs
// - Input-only analog port, read-only data
// - Analog pin 3 is conversion trigger
`timescale 1ns/10ps
`default_nettype none
`include "pmx_consts.svh"
module pmx_port_mux
    import pmx_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            rst,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output var  logic [31:0]     hrdata,
    output var  logic            hreadyout,
    output var  logic            hresp,
    // Pins
    input  wire logic [7:0]      port_eight_in,
    output var  logic [7:0]      port_eight_out,
    output var  logic [7:0]      port_eight_oe,
    output var  logic [7:0]      port_eight_pullup,
    input  wire logic [6:0]      port_nine_in,
    output var  logic [6:0]      port_nine_out,
    output var  logic [6:0]      port_nine_oe,
    input  wire logic [7:0]      analog_port_in,
    // Peripherals
    input  wire pmx_periph_out_s periph_out,
    output var  pmx_periph_in_s  periph_in
);
    typedef struct packed {
        pmx_regs_s       regs;
        pmx_bus_s        bus;
        logic [31:0]     rdata;
        logic [7:0]      p8_out;
        logic [7:0]      p8_oe;
        logic [7:0]      p8_pull;
        logic [6:0]      p9_out;
        logic [6:0]      p9_oe;
        pmx_periph_in_s  pin;
    } pmx_state_s;

    pmx_state_s state_q;
    pmx_state_s state_d;

    logic [7:0] p8_sync;
    logic [6:0] p9_sync;
    logic [7:0] pa_sync;

    // Pins are held synchronous but still double-registered to tame slow edges
    pmx_pin_sync #(.WIDTH(23)) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({port_eight_in, port_nine_in, analog_port_in}),
        .sync_out ({p8_sync, p9_sync, pa_sync})
    );

    function automatic logic [7:0] pmx_readback(input logic [7:0] dir,
                                                input logic [7:0] latch,
                                                input logic [7:0] pins);
        pmx_readback = (dir & latch) | (~dir & pins);
    endfunction : pmx_readback

    function automatic logic [31:0] pmx_zext(input logic [7:0] v);
        pmx_zext = {24'h00_0000, v};
    endfunction : pmx_zext

    logic        acc_ok;
    logic        alt8_tx0;
    logic        alt8_tx1;
    logic [7:0]  p8_alt_val;
    logic [7:0]  p8_alt_oe;
    logic [6:0]  p9_alt_val;
    logic [7:0]  p8_dir;
    logic [7:0]  p8_fn;
    logic [6:0]  p9_fn;

    always_comb begin
        state_d = state_q;
        p8_dir  = state_q.regs.port_eight_direction;
        p8_fn   = state_q.regs.port_eight_function;
        p9_fn   = state_q.regs.port_nine_function;
        acc_ok  = hsel && hready && (htrans == `PMX_HTRANS_NONSEQ || htrans == `PMX_HTRANS_SEQ);

        // Data phase of a write lands one cycle after its address phase
        if (state_q.bus.pend && state_q.bus.write) begin
            unique case (state_q.bus.index)
                `PMX_IDX_P8_DATA: state_d.regs.port_eight_data = hwdata[7:0];
                `PMX_IDX_P8_DIR:  state_d.regs.port_eight_direction = hwdata[7:0];
                `PMX_IDX_P8_FUNC: state_d.regs.port_eight_function = hwdata[7:0];
                `PMX_IDX_P8_ODE:  state_d.regs.port_eight_open_drain = hwdata[1:0];
                `PMX_IDX_P9_DATA: state_d.regs.port_nine_data = hwdata[6:0];
                `PMX_IDX_P9_DIR:  state_d.regs.port_nine_direction = hwdata[6:0];
                `PMX_IDX_P9_FUNC: state_d.regs.port_nine_function = hwdata[6:0];
                default: ;
            endcase
        end

        state_d.bus.pend  = acc_ok;
        state_d.bus.write = hwrite;
        state_d.bus.index = haddr[`PMX_ADDR_MSB:`PMX_ADDR_LSB];

        // Read data is registered at the address phase; unmapped and write-only read zero
        state_d.rdata = `PMX_WORD_ZERO;
        if (acc_ok && !hwrite) begin
            unique case (haddr[`PMX_ADDR_MSB:`PMX_ADDR_LSB])
                `PMX_IDX_P8_DATA: state_d.rdata = pmx_zext(pmx_readback(p8_dir,
                                      state_q.regs.port_eight_data, p8_sync));
                `PMX_IDX_P8_FUNC: state_d.rdata = pmx_zext(p8_fn);
                `PMX_IDX_P8_ODE:  state_d.rdata = {30'h0000_0000, state_q.regs.port_eight_open_drain};
                `PMX_IDX_P9_DATA: state_d.rdata = pmx_zext(pmx_readback({1'b0, state_q.regs.port_nine_direction},
                                      {1'b0, state_q.regs.port_nine_data}, {1'b0, p9_sync}));
                `PMX_IDX_P9_DIR:  state_d.rdata = pmx_zext({1'b0, state_q.regs.port_nine_direction});
                `PMX_IDX_P9_FUNC: state_d.rdata = pmx_zext({1'b0, p9_fn});
                `PMX_IDX_PA_DATA: state_d.rdata = pmx_zext(pa_sync);
                default:          state_d.rdata = `PMX_WORD_ZERO;
            endcase
        end

        // Alternate functions for port eight
        p8_alt_val = state_q.regs.port_eight_data;
        p8_alt_oe  = p8_dir;
        p8_alt_val[`PMX_PIN_TX0]   = periph_out.serial0_transmit;
        p8_alt_val[`PMX_PIN_TX1]   = periph_out.serial1_transmit;
        p8_alt_val[`PMX_PIN_SCK0]  = periph_out.serial0_clock_out;
        p8_alt_oe[`PMX_PIN_SCK0]   = p8_dir[`PMX_PIN_SCK0] & periph_out.serial0_clock_oe;
        p8_alt_val[`PMX_PIN_SCK1]  = periph_out.serial1_clock_out;
        p8_alt_oe[`PMX_PIN_SCK1]   = p8_dir[`PMX_PIN_SCK1] & periph_out.serial1_clock_oe;
        p8_alt_val[`PMX_PIN_CANTX] = periph_out.can_transmit;

        // Direction 1 drives; function 1 swaps in the peripheral value
        for (int i = 0; i < 8; i++) begin
            state_d.p8_out[i] = p8_fn[i] ? p8_alt_val[i] : state_q.regs.port_eight_data[i];
            state_d.p8_oe[i]  = p8_fn[i] ? p8_alt_oe[i] : p8_dir[i];
            // Pull-up only while input, under the latch bit
            state_d.p8_pull[i] = !p8_dir[i] && state_q.regs.port_eight_data[i];
        end
        // Open drain drives low only and kills the pull-up
        alt8_tx0 = state_q.regs.port_eight_open_drain[0];
        alt8_tx1 = state_q.regs.port_eight_open_drain[1];
        if (alt8_tx0) begin
            state_d.p8_oe[`PMX_PIN_TX0]   = state_d.p8_oe[`PMX_PIN_TX0] && !state_d.p8_out[`PMX_PIN_TX0];
            state_d.p8_out[`PMX_PIN_TX0]  = 1'b0;
            state_d.p8_pull[`PMX_PIN_TX0] = 1'b0;
        end
        if (alt8_tx1) begin
            state_d.p8_oe[`PMX_PIN_TX1]   = state_d.p8_oe[`PMX_PIN_TX1] && !state_d.p8_out[`PMX_PIN_TX1];
            state_d.p8_out[`PMX_PIN_TX1]  = 1'b0;
            state_d.p8_pull[`PMX_PIN_TX1] = 1'b0;
        end

        // Port nine timer outputs, gated by function bits only
        p9_alt_val = state_q.regs.port_nine_data;
        p9_alt_val[`PMX_P9_TO8]  = periph_out.timer8_out_a;
        p9_alt_val[`PMX_P9_TO9]  = periph_out.timer8_out_b;
        p9_alt_val[`PMX_P9_TOAB] = periph_out.timer9_out;
        for (int j = 0; j < 7; j++) begin
            state_d.p9_out[j] = p9_fn[j] ? p9_alt_val[j] : state_q.regs.port_nine_data[j];
            state_d.p9_oe[j]  = state_q.regs.port_nine_direction[j] | p9_fn[j];
        end

        // Peripheral inputs always see the pins, whatever the mode
        state_d.pin.serial0_receive         = p8_sync[`PMX_PIN_RX0];
        state_d.pin.serial1_receive         = p8_sync[`PMX_PIN_RX1];
        state_d.pin.serial0_clock           = p8_sync[`PMX_PIN_SCK0];
        state_d.pin.serial1_clock           = p8_sync[`PMX_PIN_SCK1];
        state_d.pin.serial0_clear_to_send_n = p8_sync[`PMX_PIN_SCK0];
        state_d.pin.serial1_clear_to_send_n = p8_sync[`PMX_PIN_SCK1];
        state_d.pin.can_receive             = p8_sync[`PMX_PIN_CANRX];
        state_d.pin.timer8_count_in_a       = p9_sync[0];
        state_d.pin.timer8_count_in_b       = p9_sync[1];
        state_d.pin.timer9_count_in_a       = p9_sync[4];
        state_d.pin.timer9_count_in_b       = p9_sync[5];
        // No gating: pure port use needs software to mask these
        state_d.pin.ext_irq_five            = p9_sync[0];
        state_d.pin.ext_irq_six             = p9_sync[1];
        state_d.pin.ext_irq_seven           = p9_sync[4];
        state_d.pin.ext_irq_eight           = p9_sync[5];
        state_d.pin.conversion_trigger_n    = pa_sync[`PMX_PA_TRIG];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q                           <= '0;
            state_q.regs.port_eight_data      <= `PMX_P8_LATCH_RST;
            state_q.regs.port_eight_direction <= `PMX_P8_ZERO;
            state_q.regs.port_eight_function  <= `PMX_P8_ZERO;
            state_q.regs.port_eight_open_drain <= `PMX_ODE_ZERO;
            state_q.regs.port_nine_data       <= `PMX_P9_ZERO;
            state_q.regs.port_nine_direction  <= `PMX_P9_ZERO;
            state_q.regs.port_nine_function   <= `PMX_P9_ZERO;
            state_q.p8_pull                   <= `PMX_P8_LATCH_RST;
            state_q.pin.serial0_clear_to_send_n <= 1'b1;
            state_q.pin.serial1_clear_to_send_n <= 1'b1;
            state_q.pin.conversion_trigger_n    <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign hrdata            = state_q.rdata;
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign port_eight_out    = state_q.p8_out;
    assign port_eight_oe     = state_q.p8_oe;
    assign port_eight_pullup = state_q.p8_pull;
    assign port_nine_out     = state_q.p9_out;
    assign port_nine_oe      = state_q.p9_oe;
    assign periph_in         = state_q.pin;
endmodule : pmx_port_mux
`default_nettype wire
